// >>> design/iex_target.sv
// Two-wire bus target: strap address, general call software reset, identity read.
// Assumes open-drain lines resolved outside; strap level steady from reset.
// Summary of operation
// - Address is 01000 plus two strap bits: SCL 00, SDA 01, GND 10, VDD 11.
// - Lowest bit of first byte after START: one reads, zero writes.
// - Acknowledge general call with write bit; never with read bit.
// - After general call, acknowledge the next byte only when it equals 06h.
// - Any general call data byte after the first gets no acknowledge.
// - STOP after acknowledged 06h pulses soft_rst and recaptures the strap; addressing resumes after bus free time.
// - Repeated START after the reset byte cancels the software reset.
// - Hardwired 24-bit identity: 12 maker, 9 part, 3 revision bits.
// - Identity read opens with START and reserved address F8h.
// - Next byte is a slave address, lowest bit ignored; only the match acknowledges.
// - Repeated START then F9h; the selected device returns identity bytes.
// - STOP, or restart toward another slave, abandons a pending identity read.
// - Identity bytes go most significant first: maker, part, revision.
// - Master not-acknowledge on final byte ends the read and releases the bus.
// - Acknowledged third byte wraps back to the first identity byte.
// - A not-acknowledge at any point stops identity transmission.
module iex_target #(
  parameter logic [iex_pkg::IEX_MFR_W-1:0] MFR_ID = 12'h5a5, // Arbitrary value
  parameter logic [iex_pkg::IEX_PART_W-1:0] PART_ID = 9'h0c3, // Arbitrary value
  parameter logic [iex_pkg::IEX_REV_W-1:0] REV_ID = 3'h1, // Arbitrary value
  parameter int TBUF_CYC = iex_pkg::IEX_TBUF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // Address strap levels
  input wire logic strap_bit_high,
  input wire logic strap_bit_low,
  // Register access toward port logic
  output logic acc_start,
  output logic acc_read,
  output logic acc_wr_stb,
  output logic [7:0] acc_wr_data,
  output logic acc_stop,
  // Software reset toward the register file
  output logic soft_rst
);
  import iex_pkg::*;

  typedef struct packed {
    iex_state_t st;
    iex_kind_t kind;
    logic [7:0] sh;
    logic [2:0] bcnt;
    logic ack_now;
    logic rd;
    logic id_armed;
    logic rst_armed;
    logic [1:0] id_idx;
    logic [1:0] strap;
    logic strap_ok;
    logic [1:0] strap_wait;
    logic sda_oe_n;
    logic acc_start;
    logic acc_read;
    logic acc_wr_stb;
    logic [7:0] acc_wr_data;
    logic acc_stop;
    logic soft_rst;
    logic [15:0] hold_cnt;
  } iex_top_t;

  iex_top_t r_q, r_d;
  logic scl_s, sda_s, hb_s, lb_s;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [6:0] my_addr;
  logic [7:0] rx_byte;
  logic [IEX_ID_BYTES*8-1:0] id_word;

  // ==========================================================================
  // Line synchronisers
  iex_sync u_sync_scl (.ref_clk(ref_clk), .nrst(nrst), .din(scl_in), .dout(scl_s));
  iex_sync u_sync_sda (.ref_clk(ref_clk), .nrst(nrst), .din(sda_in), .dout(sda_s));
  iex_sync u_sync_hb (.ref_clk(ref_clk), .nrst(nrst), .din(strap_bit_high), .dout(hb_s));
  iex_sync u_sync_lb (.ref_clk(ref_clk), .nrst(nrst), .din(strap_bit_low), .dout(lb_s));

  iex_cond u_cond (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .scl_s(scl_s),
    .sda_s(sda_s),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_ev(start_ev),
    .stop_ev(stop_ev)
  );

  // ==========================================================================
  // Address and identity word
  // strap address
  assign my_addr = {IEX_ADDR_HIGH, r_q.strap};
  assign id_word = {MFR_ID, PART_ID, REV_ID};
  assign rx_byte = {r_q.sh[6:0], sda_s};

  // ==========================================================================
  // Engine
  always_comb begin
    r_d = r_q;
    r_d.acc_start = 1'b0;
    r_d.acc_wr_stb = 1'b0;
    r_d.acc_stop = 1'b0;
    r_d.soft_rst = 1'b0;
    // Strap caught once its synchronisers hold the pin level
    r_d.strap_wait = {r_q.strap_wait[0], 1'b1};
    if (!r_q.strap_ok && r_q.strap_wait[1]) begin
      r_d.strap_ok = 1'b1;
      r_d.strap = {hb_s, lb_s};
    end
    if (r_q.st == IEX_HOLD) begin
      if (r_q.hold_cnt == 16'(TBUF_CYC)) begin
        r_d.st = IEX_IDLE;
        r_d.hold_cnt = '0;
      end else begin
        r_d.hold_cnt = r_q.hold_cnt + 16'h0001;
      end
    end else if (stop_ev) begin
      r_d.sda_oe_n = 1'b1;
      r_d.id_armed = 1'b0;
      if (r_q.kind == IEX_K_DATA) begin
        r_d.acc_stop = 1'b1;
      end
      if (r_q.rst_armed) begin
        r_d.soft_rst = 1'b1;
        r_d.rst_armed = 1'b0;
        r_d.st = IEX_HOLD;
        r_d.kind = IEX_K_NONE;
        r_d.strap_ok = 1'b0;
        r_d.hold_cnt = '0;
      end else begin
        r_d.st = IEX_IDLE;
        r_d.kind = IEX_K_NONE;
      end
    end else if (start_ev) begin
      r_d.sda_oe_n = 1'b1;
      r_d.rst_armed = 1'b0;
      if (r_q.kind == IEX_K_DATA) begin
        r_d.acc_stop = 1'b1;
      end
      r_d.st = IEX_RX;
      r_d.kind = IEX_K_ADDR;
      r_d.bcnt = '0;
    end else begin
      case (r_q.st)
        IEX_RX: begin
          if (scl_rise) begin
            r_d.sh = rx_byte;
            r_d.bcnt = r_q.bcnt + 3'h1;
            if (r_q.bcnt == IEX_BIT_LAST) begin
              r_d.st = IEX_ACK;
              r_d.ack_now = 1'b0;
              case (r_q.kind)
                IEX_K_ADDR: begin
                  r_d.rd = rx_byte[0];
                  if (rx_byte[7:1] == my_addr) begin
                    r_d.ack_now = 1'b1;
                    r_d.id_armed = 1'b0;
                    r_d.acc_start = 1'b1;
                    r_d.acc_read = rx_byte[0];
                    r_d.kind = IEX_K_DATA;
                  end else if (rx_byte[7:1] == IEX_GCALL_ADDR) begin
                    r_d.ack_now = ~rx_byte[0];
                    r_d.id_armed = 1'b0;
                    r_d.kind = rx_byte[0] ? IEX_K_NONE : IEX_K_GC;
                  end else if (rx_byte[7:1] == IEX_ID_ADDR) begin
                    if (!rx_byte[0]) begin
                      r_d.kind = IEX_K_IDSEL;
                      r_d.id_armed = 1'b0;
                    end else begin
                      r_d.ack_now = r_q.id_armed;
                      r_d.kind = r_q.id_armed ? IEX_K_DATA : IEX_K_NONE;
                      r_d.id_idx = '0;
                    end
                  end else begin
                    r_d.id_armed = 1'b0;
                    r_d.kind = IEX_K_NONE;
                  end
                end
                IEX_K_IDSEL: begin
                  r_d.ack_now = (rx_byte[7:1] == my_addr);
                  r_d.id_armed = (rx_byte[7:1] == my_addr);
                  r_d.kind = IEX_K_NONE;
                end
                IEX_K_GC: begin
                  r_d.ack_now = (rx_byte == IEX_SWRST_BYTE);
                  r_d.rst_armed = (rx_byte == IEX_SWRST_BYTE);
                  r_d.kind = IEX_K_GCX;
                end
                IEX_K_GCX: begin
                  r_d.rst_armed = 1'b0;
                end
                IEX_K_DATA: begin
                  r_d.ack_now = 1'b1;
                  r_d.acc_wr_stb = 1'b1;
                  r_d.acc_wr_data = rx_byte;
                end
                default: begin
                  r_d.ack_now = 1'b0;
                end
              endcase
            end
          end
        end
        IEX_ACK: begin
          if (scl_fall) begin
            if (r_q.bcnt == 3'h0) begin
              // Acknowledge slot opens
              r_d.sda_oe_n = ~r_q.ack_now;
              r_d.bcnt = 3'h1;
            end else begin
              // End of acknowledge slot
              r_d.sda_oe_n = 1'b1;
              r_d.bcnt = '0;
              if (r_q.ack_now && r_q.rd && r_q.kind == IEX_K_DATA) begin
                r_d.st = IEX_TX;
                r_d.sda_oe_n = id_word[IEX_ID_BYTES*8-1];
                r_d.bcnt = 3'h1;
              end else if (r_q.ack_now || r_q.kind == IEX_K_GCX
                  || r_q.kind == IEX_K_IDSEL) begin
                r_d.st = IEX_RX;
              end else begin
                // No acknowledge: stay off the bus
                r_d.st = IEX_IGNORE;
              end
            end
          end
        end
        IEX_TX: begin
          if (scl_fall) begin
            if (r_q.bcnt == 3'h0) begin
              r_d.st = IEX_MACK;
              r_d.sda_oe_n = 1'b1;
            end else begin
              r_d.sda_oe_n = id_word[(IEX_ID_BYTES - 1 - 32'(r_q.id_idx)) * 8
                + 32'(IEX_BIT_LAST - r_q.bcnt)];
              r_d.bcnt = r_q.bcnt + 3'h1;
            end
          end
        end
        IEX_MACK: begin
          if (scl_rise) begin
            if (sda_s) begin
              r_d.st = IEX_IGNORE;
              r_d.kind = IEX_K_NONE;
            end else begin
              r_d.id_idx = (r_q.id_idx == IEX_ID_LAST) ? 2'h0 : r_q.id_idx + 2'h1;
              r_d.st = IEX_ACK;
              r_d.ack_now = 1'b0;
              r_d.sda_oe_n = 1'b1;
            end
          end
        end
        IEX_IGNORE, IEX_IDLE: begin
          r_d.sda_oe_n = 1'b1;
        end
        default: begin
          r_d.st = IEX_IDLE;
        end
      endcase
    end
    // Transmit start of next identity byte
    if (r_q.st == IEX_ACK && r_q.rd && r_q.kind == IEX_K_DATA && r_q.sda_oe_n
        && !r_q.ack_now && scl_fall && !start_ev && !stop_ev) begin
      r_d.st = IEX_TX;
      r_d.sda_oe_n = id_word[(IEX_ID_BYTES - 1 - 32'(r_d.id_idx)) * 8 + 7];
      r_d.bcnt = 3'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '{st: IEX_IDLE, kind: IEX_K_NONE, sda_oe_n: 1'b1, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe_n = r_q.sda_oe_n;
  assign acc_start = r_q.acc_start;
  assign acc_read = r_q.acc_read;
  assign acc_wr_stb = r_q.acc_wr_stb;
  assign acc_wr_data = r_q.acc_wr_data;
  assign acc_stop = r_q.acc_stop;
  assign soft_rst = r_q.soft_rst;
endmodule

// >>> design/iex_pkg.sv
// Package for the two-wire target front end: address, reset and identity constants.
// Assumes a 100 MHz system clock and bus lines sampled from outside its domain.
package iex_pkg;
  // ==========================================================================
  // Addresses
  localparam logic [4:0] IEX_ADDR_HIGH = 5'h08;
  localparam logic [6:0] IEX_GCALL_ADDR = 7'h00;
  localparam logic [6:0] IEX_ID_ADDR = 7'h7c;
  localparam logic [7:0] IEX_SWRST_BYTE = 8'h06;
  // ==========================================================================
  // Strap codes
  localparam logic [1:0] IEX_STRAP_SCL = 2'h0;
  localparam logic [1:0] IEX_STRAP_SDA = 2'h1;
  localparam logic [1:0] IEX_STRAP_GND = 2'h2;
  localparam logic [1:0] IEX_STRAP_VDD = 2'h3;
  // ==========================================================================
  // Identity fields and sizes
  localparam int IEX_MFR_W = 12;
  localparam int IEX_PART_W = 9;
  localparam int IEX_REV_W = 3;
  localparam int IEX_ID_BYTES = 3;
  localparam logic [2:0] IEX_BIT_LAST = 3'h7;
  localparam logic [1:0] IEX_ID_LAST = 2'h2;
  // ==========================================================================
  // Bus free time before re-addressing after a software reset
  localparam int IEX_CLK_MHZ = 100;
  localparam int IEX_TBUF_NS = 500;
  localparam int IEX_TBUF_CYC = (IEX_TBUF_NS * IEX_CLK_MHZ + 999) / 1000;
  // ==========================================================================
  // Engine states
  typedef enum logic [6:0] {
    IEX_IDLE = 7'h01,
    IEX_RX = 7'h02,
    IEX_ACK = 7'h04,
    IEX_TX = 7'h08,
    IEX_MACK = 7'h10,
    IEX_IGNORE = 7'h20,
    IEX_HOLD = 7'h40
  } iex_state_t;
  // Meaning of the byte being received
  typedef enum logic [5:0] {
    IEX_K_ADDR = 6'h01,
    IEX_K_GC = 6'h02,
    IEX_K_GCX = 6'h04,
    IEX_K_IDSEL = 6'h08,
    IEX_K_DATA = 6'h10,
    IEX_K_NONE = 6'h20
  } iex_kind_t;
endpackage

// >>> design/iex_sync.sv
// Two flip-flop synchroniser for one bus line.
// Assumes an asynchronous level arriving from outside the ref_clk domain.
module iex_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Line
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic first;
    logic second;
  } iex_sync_t;
  iex_sync_t s_q, s_d;
  // ==========================================================================
  // Idle-high sampling chain
  always_comb begin
    s_d.first = din;
    s_d.second = s_q.first;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '1;
    end else begin
      s_q <= s_d;
    end
  end
  assign dout = s_q.second;
endmodule

// >>> design/iex_cond.sv
// Bus condition detector: clock edges, START and STOP on synchronised lines.
// Assumes both inputs already pass a synchroniser on ref_clk.
module iex_cond (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Synchronised lines
  input wire logic scl_s,
  input wire logic sda_s,
  // Events
  output logic scl_rise,
  output logic scl_fall,
  output logic start_ev,
  output logic stop_ev
);
  typedef struct packed {
    logic scl;
    logic sda;
  } iex_cond_t;
  iex_cond_t c_q, c_d;
  // ==========================================================================
  // Previous line levels
  always_comb begin
    c_d.scl = scl_s;
    c_d.sda = sda_s;
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      c_q <= '1;
    end else begin
      c_q <= c_d;
    end
  end
  assign scl_rise = scl_s & ~c_q.scl;
  assign scl_fall = ~scl_s & c_q.scl;
  assign start_ev = scl_s & c_q.scl & c_q.sda & ~sda_s;
  assign stop_ev = scl_s & c_q.scl & ~c_q.sda & sda_s;
endmodule

// >>> dv/iex_target_asserts.sv
// Assertions on the two-wire target ports.
// Assumes the bench resolves the open-drain data line onto sda_in.
module iex_target_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  // Strobes
  input wire logic acc_start,
  input wire logic acc_read,
  input wire logic acc_wr_stb,
  input wire logic soft_rst
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] low_age_q;
  logic [5:0] low_age_d;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================================
  // Cycles since data was last pulled low
  always_comb begin
    low_age_d = low_age_q;
    if (!sda_oe_n) begin
      low_age_d = 6'h0;
    end else if (low_age_q != 6'h3f) begin
      low_age_d = low_age_q + 6'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      low_age_q <= 6'h3f;
    end else begin
      low_age_q <= low_age_d;
    end
  end
  // ==========================================================================
  // Properties
  drive_on_low_a: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("drive began with clock high");
  drive_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("drive changed with clock high");
  drive_hold_a: assert property ($fell(sda_oe_n) |=> !sda_oe_n [*8])
    else $error("drive too short");
  stop_release_a: assert property (scl_in && $rose(sda_in) |=> sda_oe_n [*6])
    else $error("drive after stop");
  soft_pulse_a: assert property (soft_rst |=> !soft_rst)
    else $error("soft reset too long");
  soft_bus_a: assert property (soft_rst |-> scl_in && sda_in)
    else $error("soft reset without stop");
  soft_quiet_a: assert property (soft_rst |=> sda_oe_n [*8])
    else $error("drive during free time");
  soft_ack_a: assert property (soft_rst |-> low_age_q < 6'd48)
    else $error("soft reset without ack");
  start_ack_a: assert property (acc_start |-> (low_age_q < 6'd16) or (##[0:40] !sda_oe_n))
    else $error("access without ack");
  soft_seen_c: cover property (soft_rst);
  read_seen_c: cover property (acc_start && acc_read);
  write_seen_c: cover property (acc_wr_stb);
endmodule

// >>> dv/iex_master_model.sv
// Two-wire bus master model: clock and open-drain data release.
// Assumes a pull-up on data, resolved in the bench.
module iex_master_model (
  // Bus
  output logic scl,
  output logic sda_rel,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  int slow = 0;
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // ==========================================================================
  // Bit and conditions
  task automatic bit_io(input logic b, output logic r);
    #(55 + slow) sda_rel = b;
    #10 scl = 1'b1;
    #30 r = sda;
    #30 scl = 1'b0;
  endtask
  task automatic start();
    if (!scl) begin
      #(55 + slow) sda_rel = 1'b1;
      #10 scl = 1'b1;
    end
    #30 sda_rel = 1'b0;
    #30 scl = 1'b0;
  endtask
  task automatic stop();
    #(55 + slow) sda_rel = 1'b0;
    #10 scl = 1'b1;
    #30 sda_rel = 1'b1;
    #100;
  endtask
  // ==========================================================================
  // Address and data
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

// >>> dv/iex_target_test.sv
// Self-checking bench for the two-wire target.
// Assumes the package, the master model and the checker are compiled first.
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module iex_target_test;
  timeunit 1ns;
  timeprecision 100ps;
  import iex_pkg::*;
  localparam logic [11:0] T_MFR = 12'h3c7; // Arbitrary value
  localparam logic [8:0] T_PART = 9'h12b; // Arbitrary value
  localparam logic [2:0] T_REV = 3'h5; // Arbitrary value
  localparam int T_TBUF = 2;
  logic ref_clk, nrst, scl, sda, sda_rel, sda_out, sda_oe_n, strap_hi, strap_lo;
  logic acc_start, acc_read, acc_wr_stb, acc_stop, soft_rst;
  logic [7:0] acc_wr_data;
  logic [31:0] rs = 32'h703bb60c;
  logic [7:0] idq[$];
  int num_errors = 0;
  int samples_checked = 0;
  int n[4];
  int e[4];
  // ==========================================================================
  // Clock, bus, design and master
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  assign sda = sda_rel & (sda_oe_n | sda_out);
  iex_target #(.MFR_ID(T_MFR), .PART_ID(T_PART), .REV_ID(T_REV), .TBUF_CYC(T_TBUF)) uut (
    .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .strap_bit_high(strap_hi), .strap_bit_low(strap_lo),
    .acc_start(acc_start), .acc_read(acc_read), .acc_wr_stb(acc_wr_stb),
    .acc_wr_data(acc_wr_data), .acc_stop(acc_stop), .soft_rst(soft_rst));
  iex_master_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda));
  always @(posedge ref_clk) begin
    n[0] += (acc_start === 1'b1);
    n[1] += (acc_wr_stb === 1'b1);
    n[2] += (acc_stop === 1'b1);
    n[3] += (soft_rst === 1'b1);
  end
  // ==========================================================================
  // Helpers
  function automatic logic [7:0] rnd8();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  task automatic do_reset(input logic [1:0] s);
    nrst = 1'b0;
    {strap_hi, strap_lo} = s;
    repeat (12) @(posedge ref_clk);
    #1 nrst = 1'b1;
    n = '{default: 0};
    e = '{default: 0};
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] d, input logic x);
    logic a;
    m.wbyte(d, a);
    `CHK(a, x)
  endtask
  task automatic one(input logic [7:0] d, input logic x);
    m.start();
    wr(d, x);
    m.stop();
  endtask
  task automatic chk_cnt();
    for (int i = 0; i < 4; i++) `CHK(n[i], e[i])
  endtask
  task automatic id_read(input logic [7:0] sel, input logic ok, input int cnt);
    logic [7:0] b;
    m.start();
    wr(8'hf8, 1'b0);
    wr(sel, ok);
    m.start();
    wr(8'hf9, ok);
    for (int i = 0; i < cnt; i++) begin
      m.rbyte(i == cnt - 1, b);
      `CHK(b, idq[i % 3])
    end
    m.stop();
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios, one pass per strap code
  initial begin
    logic [6:0] own;
    logic [7:0] d, bad;
    int cnt;
    idq = '{T_MFR[11:4], {T_MFR[3:0], T_PART[8:5]}, {T_PART[4:0], T_REV}};
    for (int k = 0; k < 4; k++) begin
      do_reset(k[1:0]);
      m.slow = (k == 3) ? 200 : 0;
      own = {IEX_ADDR_HIGH, k[1:0]};
      bad = {IEX_ADDR_HIGH, ~k[1:0], 1'b0};
      d = rnd8();
      cnt = (k == 0) ? 1 : 4 + int'(rnd8() % 8'd4);
      m.start();
      wr({own, 1'b0}, 1'b1);
      wr(d, 1'b1);
      `CHK(acc_read, 1'b0)
      `CHK(acc_wr_data, d)
      m.stop();
      m.start();
      wr({own, 1'b1}, 1'b1);
      `CHK(acc_read, 1'b1)
      m.rbyte(1'b1, d);
      m.stop();
      one(bad, 1'b0);
      one(8'h01, 1'b0);
      e = '{2, 1, 1, 0};
      m.start();
      wr(8'h00, 1'b1);
      wr(8'h05, 1'b0);
      wr(8'h06, 1'b0);
      m.stop();
      chk_cnt();
      m.start();
      wr(8'h00, 1'b1);
      wr(8'h06, 1'b1);
      m.start();
      wr({own, 1'b0}, 1'b1);
      m.stop();
      e = '{3, 1, 2, 0};
      chk_cnt();
      one(8'h00, 1'b1);
      m.start();
      wr(8'h00, 1'b1);
      wr(8'h06, 1'b1);
      m.stop();
      repeat (T_TBUF + 2) @(posedge ref_clk);
      #1;
      one({own, 1'b0}, 1'b1);
      e = '{4, 1, 3, 1};
      chk_cnt();
      id_read({own, 1'b1}, 1'b1, cnt);
      id_read(bad, 1'b0, 0);
      m.start();
      wr(8'hf8, 1'b0);
      wr({own, 1'b0}, 1'b1);
      m.stop();
      one(8'hf9, 1'b0);
    end
    final_report();
  end
  initial begin
    #600000;
    num_errors++;
    final_report();
  end
endmodule

bind iex_target iex_target_asserts chk (
  .ref_clk(ref_clk), .nrst(nrst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .acc_start(acc_start), .acc_read(acc_read), .acc_wr_stb(acc_wr_stb), .soft_rst(soft_rst));
